// File: core/standby_reset_controller.sv
// Standby (HALT/STOP) and reset sequencer with APB status registers.
// Assumes inputs synchronous to i_sys_clk except the reset pin and supply monitor, which are synchronised, and an APB master outside.
//
// Contract
// - Pin reset in HALT does reset processing
// - Maskable release decided by mask, level, enable
// - Non-maskable request always leads to service; the code acts on it in HALT only, and STOP ignores it
// - HALT release waits 8 or 2 clocks
// - Unmasked test input resumes next instruction
// - STOP stops oscillator and CPU clock
// - Pending request at STOP drops to wait
// - Unmasked request releases STOP after wait
// - Reset in STOP waits, then resets
// - STOP halts listed peripherals and first irq
// - Event counter counts only on event inputs
// - Reset from pin, watchdog or monitor
// - Reset and wait: pins float, outputs low
// - Execution waits 2^17 clocks after reset
// - Watchdog reset releases itself at once
// - Monitor threshold follows operating state
// - Oscillator stopped while reset asserted
// - Reset from STOP keeps STOP registers
// - Reset loads vector and tabulated values
// - Only program counter undefined in reset
// - Monitor reset sets power fail flag
// - Status reads one only after monitor reset
// - Unlock flags invalid only on monitor reset
`timescale 1ns/100ps
`include "standby_reset_consts.svh"

module standby_reset_controller #(
	parameter int RESET_WAIT_CYCLES = `RESET_WAIT_DEF,
	parameter int OSC_EXP_BASE = `OSC_EXP_BASE_DEF
) (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [31:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_reset_pin_n,
	input wire logic i_wdt_overflow,
	input wire logic i_supply_monitor_reset,
	input wire logic i_cpu_clk_full,
	input wire logic i_halt_exec,
	input wire logic i_stop_exec,
	input wire logic i_irq_req,
	input wire logic i_request_mask_flag,
	input wire logic i_level_select_flag,
	input wire logic i_interrupt_enable_flag,
	input wire logic i_in_service_flag,
	input wire logic i_nmi_req,
	input wire logic i_test_in,
	input wire logic i_test_mask,
	output logic o_cpu_clk_stop,
	output logic o_osc_stop,
	output logic o_periph_stop,
	output logic o_event_count_only,
	output logic o_internal_reset,
	output logic o_pins_hiz,
	output logic o_dedicated_output_pins_low,
	output logic o_hold_stop_regs,
	output logic o_pc_undefined,
	output logic o_load_reset_values,
	output logic o_synth_unlock_invalidate,
	output logic o_resume,
	output logic o_resume_service,
	output logic o_resume_vector,
	output logic [1:0] o_reset_source,
	output logic [1:0] o_monitor_threshold
);

	localparam logic [`CNT_W-1:0] RESET_LOAD = `CNT_W'(RESET_WAIT_CYCLES - 1);

	// Release decision shared by HALT, STOP and the STOP-entry check
	function automatic logic [1:0] release_action(input logic mask,
			input logic level, input logic ie, input logic in_service_flag);
		logic [1:0] act;
		act = `ACT_HOLD;
		if (!mask) begin
			if (!level)
				act = ie ? `ACT_SERVICE : `ACT_NEXT;
			else
				act = (ie && in_service_flag) ? `ACT_SERVICE : `ACT_NEXT;
		end
		return act;
	endfunction

	// Oscillation wait length from the select field, minus one
	function automatic logic [`CNT_W-1:0] osc_wait_len(
			input logic [`OWS_W-1:0] sel);
		logic [`CNT_W-1:0] one;
		one = `CNT_W'(1);
		return (one << (OSC_EXP_BASE + int'(sel))) - one;
	endfunction

	// Byte address of a register index
	function automatic logic [31:0] addr_of(input logic [15:0] idx);
		return {14'h0000, idx, 2'b00};
	endfunction

	// Synchronisers: stage one feeds stage two only
	logic pin_low_meta;
	logic pin_low_sync;
	logic mon_meta;
	logic mon_sync;
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			pin_low_meta <= 1'b0;
			pin_low_sync <= 1'b0;
			mon_meta <= 1'b0;
			mon_sync <= 1'b0;
		end else begin
			pin_low_meta <= ~i_reset_pin_n;
			pin_low_sync <= pin_low_meta;
			mon_meta <= i_supply_monitor_reset;
			mon_sync <= mon_meta;
		end
	end

	// Sequencer state
	standby_reset_pkg::ctl_state_e state;
	standby_reset_pkg::ctl_state_e next_state;
	standby_reset_pkg::count_t cnt;
	standby_reset_pkg::count_t next_cnt;
	logic [1:0] act;
	logic [1:0] next_act;
	logic from_stop;
	logic next_from_stop;
	logic powerup;
	logic next_powerup;
	logic [1:0] src;
	logic [1:0] next_src;
	logic [`OWS_W-1:0] osc_wait_select;
	logic [`OWS_W-1:0] next_osc_wait_select;
	logic power_fail_flag;
	logic next_power_fail_flag;
	logic reset_req;
	logic irq_open;
	logic test_open;
	logic [1:0] irq_act;
	logic apb_done;
	logic apb_wr;
	logic apb_rd;

	// Request decoding seen by the sequencer
	always_comb begin
		reset_req = pin_low_sync | mon_sync | i_wdt_overflow;
		irq_open = i_irq_req & ~i_request_mask_flag;
		test_open = i_test_in & ~i_test_mask;
		irq_act = release_action(i_request_mask_flag, i_level_select_flag,
			i_interrupt_enable_flag, i_in_service_flag);
		apb_done = i_psel & i_penable & o_pready;
		apb_wr = apb_done & i_pwrite;
		apb_rd = apb_done & ~i_pwrite;
	end

	// Next state of the sequencer and its event outputs
	logic next_load_reset_values;
	logic next_unlock_inv;
	logic next_resume;
	logic next_resume_service;
	logic next_resume_vector;
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_act = act;
		next_from_stop = from_stop;
		next_powerup = powerup;
		next_src = src;
		next_load_reset_values = 1'b0;
		next_unlock_inv = 1'b0;
		next_resume = 1'b0;
		next_resume_service = 1'b0;
		next_resume_vector = 1'b0;
		if (reset_req && state != standby_reset_pkg::ST_RESET) begin
			next_state = standby_reset_pkg::ST_RESET;
			next_from_stop = (state == standby_reset_pkg::ST_STOP);
			next_load_reset_values = 1'b1;
			next_act = `ACT_RESET;
			if (mon_sync) begin
				next_src = `SRC_MON;
				next_unlock_inv = 1'b1;
			end else if (pin_low_sync) begin
				next_src = `SRC_PIN;
			end else begin
				next_src = `SRC_WDT;
			end
		end else begin
			case (state)
			standby_reset_pkg::ST_RUN: begin
				if (i_stop_exec) begin
					if (irq_open || test_open) begin
						// Request already pending: skip STOP proper
						next_state = standby_reset_pkg::ST_OSC_WAIT;
						next_cnt = osc_wait_len(osc_wait_select);
						next_act = irq_open ? irq_act : `ACT_NEXT;
					end else begin
						next_state = standby_reset_pkg::ST_STOP;
					end
				end else if (i_halt_exec) begin
					next_state = standby_reset_pkg::ST_HALT;
				end
			end
			standby_reset_pkg::ST_HALT: begin
				if (i_nmi_req) begin
					next_state = standby_reset_pkg::ST_REL_WAIT;
					next_cnt = `WAIT_SERVICE;
					next_act = `ACT_SERVICE;
				end else if (irq_open) begin
					next_state = standby_reset_pkg::ST_REL_WAIT;
					next_cnt = (irq_act == `ACT_SERVICE) ?
						`WAIT_SERVICE : `WAIT_NEXT;
					next_act = irq_act;
				end else if (test_open) begin
					next_state = standby_reset_pkg::ST_REL_WAIT;
					next_cnt = `WAIT_NEXT;
					next_act = `ACT_NEXT;
				end
			end
			standby_reset_pkg::ST_STOP: begin
				if (irq_open || test_open) begin
					next_state = standby_reset_pkg::ST_OSC_WAIT;
					next_cnt = osc_wait_len(osc_wait_select);
					next_act = irq_open ? irq_act : `ACT_NEXT;
				end
			end
			standby_reset_pkg::ST_RESET: begin
				// Watchdog reset is a pulse, so it releases at once
				if (!pin_low_sync && !mon_sync) begin
					next_state = standby_reset_pkg::ST_OSC_WAIT;
					next_cnt = RESET_LOAD;
				end
			end
			standby_reset_pkg::ST_OSC_WAIT,
			standby_reset_pkg::ST_REL_WAIT: begin
				if (cnt == '0) begin
					next_state = standby_reset_pkg::ST_RUN;
					next_resume = 1'b1;
					next_resume_service = (act == `ACT_SERVICE);
					next_resume_vector = (act == `ACT_RESET);
					next_from_stop = 1'b0;
					if (act == `ACT_RESET)
						next_powerup = 1'b0;
				end else begin
					next_cnt = cnt - `CNT_W'(1);
				end
			end
			default: begin
				next_state = standby_reset_pkg::ST_RESET;
			end
			endcase
		end
	end

	// Registers the sequencer
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			state <= standby_reset_pkg::ST_RESET;
			cnt <= '0;
			act <= `ACT_RESET;
			from_stop <= 1'b0;
			powerup <= 1'b1;
			src <= `SRC_NONE;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			act <= next_act;
			from_stop <= next_from_stop;
			powerup <= next_powerup;
			src <= next_src;
		end
	end

	// Level outputs derived from the next state, so they are flops
	logic next_reset_phase;
	logic next_cpu_clk_stop;
	logic next_osc_stop;
	logic next_stop_mode;
	logic [1:0] next_threshold;
	always_comb begin
		next_reset_phase = (next_state == standby_reset_pkg::ST_RESET) ||
			(next_state == standby_reset_pkg::ST_OSC_WAIT &&
			next_act == `ACT_RESET);
		next_cpu_clk_stop = (next_state != standby_reset_pkg::ST_RUN);
		next_osc_stop = (next_state == standby_reset_pkg::ST_STOP) ||
			(next_state == standby_reset_pkg::ST_RESET);
		next_stop_mode = (next_state == standby_reset_pkg::ST_STOP);
		if (next_powerup || next_stop_mode)
			next_threshold = next_stop_mode && !next_powerup ?
				`THR_2V5 : `THR_3V5;
		else
			next_threshold = i_cpu_clk_full ? `THR_4V5 : `THR_3V5;
	end

	// Registers the control outputs
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			o_cpu_clk_stop <= 1'b1;
			o_osc_stop <= 1'b1;
			o_periph_stop <= 1'b0;
			o_event_count_only <= 1'b0;
			o_internal_reset <= 1'b1;
			o_pins_hiz <= 1'b1;
			o_dedicated_output_pins_low <= 1'b1;
			o_hold_stop_regs <= 1'b0;
			o_pc_undefined <= 1'b1;
			o_load_reset_values <= 1'b0;
			o_synth_unlock_invalidate <= 1'b0;
			o_resume <= 1'b0;
			o_resume_service <= 1'b0;
			o_resume_vector <= 1'b0;
			o_reset_source <= `SRC_NONE;
			o_monitor_threshold <= `THR_3V5;
		end else begin
			o_cpu_clk_stop <= next_cpu_clk_stop;
			o_osc_stop <= next_osc_stop;
			o_periph_stop <= next_stop_mode;
			o_event_count_only <= next_stop_mode;
			o_internal_reset <= (next_state == standby_reset_pkg::ST_RESET);
			o_pins_hiz <= next_reset_phase;
			o_dedicated_output_pins_low <= next_reset_phase;
			o_hold_stop_regs <= next_reset_phase & next_from_stop;
			o_pc_undefined <= next_reset_phase;
			o_load_reset_values <= next_load_reset_values & ~next_from_stop;
			o_synth_unlock_invalidate <= next_unlock_inv;
			o_resume <= next_resume;
			o_resume_service <= next_resume_service;
			o_resume_vector <= next_resume_vector;
			o_reset_source <= next_src;
			o_monitor_threshold <= next_threshold;
		end
	end

	// Software state: wait select and power fail flag
	always_comb begin
		next_osc_wait_select = osc_wait_select;
		next_power_fail_flag = power_fail_flag;
		if (apb_wr && i_paddr == addr_of(`OWS_IDX))
			next_osc_wait_select = i_pwdata[`OWS_W-1:0];
		if (next_load_reset_values && !next_from_stop)
			next_osc_wait_select = `OWS_RESET;
		// Read clears; a monitor reset in the same cycle wins
		if (apb_rd && i_paddr == addr_of(`PFS_IDX))
			next_power_fail_flag = 1'b0;
		if (next_src == `SRC_MON && next_load_reset_values)
			next_power_fail_flag = `PFS_SET;
	end

	// Bus answer: pready rises in the first access cycle
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic mapped;
	always_comb begin
		mapped = (i_paddr == addr_of(`PFS_IDX)) ||
			(i_paddr == addr_of(`OWS_IDX)) ||
			(i_paddr == addr_of(`CST_IDX));
		next_pready = i_psel & ~i_penable;
		next_pslverr = i_psel & ~i_penable & ~mapped;
		next_prdata = '0;
		if (i_psel && !i_penable && !i_pwrite) begin
			if (i_paddr == addr_of(`PFS_IDX))
				next_prdata[`PFS_FLAG_BIT] = power_fail_flag;
			else if (i_paddr == addr_of(`OWS_IDX))
				next_prdata[`OWS_W-1:0] = osc_wait_select;
			else if (i_paddr == addr_of(`CST_IDX))
				next_prdata[9:0] = {src, act, state};
		end
	end

	// Registers the bus slave and software state
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			o_prdata <= '0;
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			osc_wait_select <= `OWS_RESET;
			power_fail_flag <= 1'b0;
		end else begin
			o_prdata <= next_prdata;
			o_pready <= next_pready;
			o_pslverr <= next_pslverr;
			osc_wait_select <= next_osc_wait_select;
			power_fail_flag <= next_power_fail_flag;
		end
	end

	// Checks next to the sequencer; all share one clock and one reset
	default clocking assert_clk @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rstn);
	AST_NMI_SERVICE: assert property (
		state == standby_reset_pkg::ST_HALT && i_nmi_req && !reset_req
		|=> act == `ACT_SERVICE && cnt == `WAIT_SERVICE)
		else $error("NMI in HALT did not select service wait");
	AST_MASK_HOLDS: assert property (
		state == standby_reset_pkg::ST_HALT && !reset_req && !i_nmi_req &&
		(!i_irq_req || i_request_mask_flag) && (!i_test_in || i_test_mask)
		|=> state == standby_reset_pkg::ST_HALT)
		else $error("Masked sources left HALT");
	AST_LEVEL_SEL: assert property (
		state == standby_reset_pkg::ST_HALT && !reset_req && !i_nmi_req &&
		irq_open && i_level_select_flag && !i_in_service_flag
		|=> act == `ACT_NEXT && cnt == `WAIT_NEXT)
		else $error("Level select with service flag 0 gave service");
	AST_NEXT_WAIT: assert property (
		state == standby_reset_pkg::ST_REL_WAIT && cnt == `WAIT_NEXT &&
		!reset_req ##1 !reset_req |=> o_resume)
		else $error("Short HALT release wait wrong");
	AST_STOP_CLOCKS: assert property (
		state == standby_reset_pkg::ST_STOP |-> o_osc_stop && o_periph_stop
		&& o_event_count_only && o_cpu_clk_stop)
		else $error("STOP outputs not asserted");
	AST_PENDING_STOP: assert property (
		state == standby_reset_pkg::ST_RUN && i_stop_exec && irq_open &&
		!reset_req |=> state == standby_reset_pkg::ST_OSC_WAIT && !o_osc_stop)
		else $error("Pending request at STOP did not skip STOP");
	AST_RESET_PINS: assert property (
		state == standby_reset_pkg::ST_RESET |-> o_pins_hiz &&
		o_dedicated_output_pins_low && o_osc_stop)
		else $error("Pins or oscillator wrong during reset");
	AST_WDT_SELF: assert property (
		state == standby_reset_pkg::ST_RESET && !pin_low_sync && !mon_sync
		&& !i_wdt_overflow |=> state == standby_reset_pkg::ST_OSC_WAIT &&
		cnt == RESET_LOAD)
		else $error("Reset did not release into full wait");
	AST_PF_FLAG: assert property (
		state != standby_reset_pkg::ST_RESET && mon_sync
		|=> power_fail_flag && o_synth_unlock_invalidate)
		else $error("Monitor reset did not set power fail flag");
	AST_PF_KEEP: assert property (
		!mon_sync && !apb_rd |=> power_fail_flag == $past(power_fail_flag))
		else $error("Power fail flag changed without cause");

endmodule

// File: core/standby_reset_consts.svh
// Constants of the standby and reset controller: offsets, fields, counts.
// Assumes inclusion by bare name from the package and the design file.
`ifndef STANDBY_RESET_CONSTS_SVH
`define STANDBY_RESET_CONSTS_SVH

// Register indices; the byte address on APB is four times the index
`define PFS_IDX 16'hffbf
`define OWS_IDX 16'hffc0
`define CST_IDX 16'hffc1

// Field layout and reset values
`define PFS_FLAG_BIT 0
`define OWS_W 3
`define OWS_RESET 3'h4
`define PFS_SET 1'b1

// Counter width and oscillation waits
`define CNT_W 24
`define RESET_WAIT_DEF 131072
`define OSC_EXP_BASE_DEF 14
`define WAIT_SERVICE 24'h000007
`define WAIT_NEXT 24'h000001

// Release decisions
`define ACT_HOLD 2'h0
`define ACT_NEXT 2'h1
`define ACT_SERVICE 2'h2
`define ACT_RESET 2'h3

// Reset source codes
`define SRC_NONE 2'h0
`define SRC_PIN 2'h1
`define SRC_WDT 2'h2
`define SRC_MON 2'h3

// Supply monitor threshold codes
`define THR_3V5 2'h0
`define THR_2V5 2'h1
`define THR_4V5 2'h2

`endif

// File: core/standby_reset_pkg.sv
// Types shared by the standby and reset controller.
// Assumes the constants header is reachable on the include path.
`include "standby_reset_consts.svh"

package standby_reset_pkg;

	// One-hot controller states
	typedef enum logic [5:0] {
		ST_RUN = 6'h01,
		ST_HALT = 6'h02,
		ST_STOP = 6'h04,
		ST_RESET = 6'h08,
		ST_OSC_WAIT = 6'h10,
		ST_REL_WAIT = 6'h20
	} ctl_state_e;

	typedef logic [`CNT_W-1:0] count_t;

endpackage

// File: tb/cpu_irq_model.sv
// Behavioural processor core and interrupt request logic for the sequencer.
// Assumes bench commands change just after a rising clock edge.
`timescale 1ns/100ps

module cpu_irq_model (
	input wire logic i_sys_clk,
	input wire logic [2:0] i_cmd,
	input wire logic [3:0] i_flags,
	input wire logic i_resume,
	output logic o_halt_exec,
	output logic o_stop_exec,
	output logic o_irq_req,
	output logic [3:0] o_flags,
	output logic o_nmi_req,
	output logic o_test_in,
	output logic o_test_mask
);
	// Quiet lines at time zero so the block never sees an unknown
	initial begin
		o_halt_exec = 1'b0;
		o_stop_exec = 1'b0;
		o_irq_req = 1'b0;
		o_flags = 4'hf;
		o_nmi_req = 1'b0;
		o_test_in = 1'b0;
		o_test_mask = 1'b1;
	end

	// Commands: 1 halt, 2 stop, 3 maskable, 4 non-maskable, 5 test.
	// Requests stand until restart, as the core clears all three on any restart
	always @(posedge i_sys_clk) begin
		o_halt_exec <= (i_cmd == 3'h1);
		o_stop_exec <= (i_cmd == 3'h2);
		if (i_cmd == 3'h3) begin
			o_irq_req <= 1'b1;
			o_flags <= i_flags;
		end
		if (i_cmd == 3'h4) o_nmi_req <= 1'b1;
		if (i_cmd == 3'h5) begin
			o_test_in <= 1'b1;
			o_test_mask <= i_flags[3];
		end
		if (i_resume) begin
			o_irq_req <= 1'b0;
			o_nmi_req <= 1'b0;
			o_test_in <= 1'b0;
		end
	end
endmodule

// File: tb/standby_reset_controller_tb.sv
// Self-checking bench for the standby and reset sequencer.
// Assumes the design, its constants header and the core model compiled.
`timescale 1ns/100ps
`include "standby_reset_consts.svh"

`define CHK(g, e) begin \
	comparisons++; \
	if ((g) !== (e)) begin \
		num_errors++; \
		$display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); \
	end \
end

module standby_reset_controller_tb;
	localparam int rw = 16;
	localparam int ob = 2;
	localparam logic [31:0] a_pfs = 32'(`PFS_IDX) * 4;
	localparam logic [31:0] a_ows = 32'(`OWS_IDX) * 4;
	logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr, er;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic pin_n, wdt, mon, cpu_full, halt_x, stop_x, irq, nmi, tin, tmask;
	logic [2:0] cmd;
	logic [3:0] flags, fq, f;
	logic cstop, ostop, pstop, evo, irst, hiz, dlow, hold, pcu, ldv, unl;
	logic res, rsv, rvec;
	logic [1:0] src, thr;
	int num_errors = 0;
	int comparisons = 0;
	int n, sel;
	int n_load = 0;
	int n_unl = 0;

	standby_reset_controller #(.RESET_WAIT_CYCLES(rw), .OSC_EXP_BASE(ob))
	i_dut (.i_sys_clk(sys_clk), .i_rstn(rstn), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_reset_pin_n(pin_n), .i_wdt_overflow(wdt),
		.i_supply_monitor_reset(mon), .i_cpu_clk_full(cpu_full),
		.i_halt_exec(halt_x), .i_stop_exec(stop_x), .i_irq_req(irq),
		.i_request_mask_flag(fq[3]), .i_level_select_flag(fq[2]),
		.i_interrupt_enable_flag(fq[1]), .i_in_service_flag(fq[0]),
		.i_nmi_req(nmi), .i_test_in(tin), .i_test_mask(tmask),
		.o_cpu_clk_stop(cstop), .o_osc_stop(ostop), .o_periph_stop(pstop),
		.o_event_count_only(evo), .o_internal_reset(irst),
		.o_pins_hiz(hiz), .o_dedicated_output_pins_low(dlow),
		.o_hold_stop_regs(hold), .o_pc_undefined(pcu),
		.o_load_reset_values(ldv), .o_synth_unlock_invalidate(unl),
		.o_resume(res), .o_resume_service(rsv), .o_resume_vector(rvec),
		.o_reset_source(src), .o_monitor_threshold(thr));

	cpu_irq_model i_core (.i_sys_clk(sys_clk), .i_cmd(cmd), .i_flags(flags),
		.i_resume(res), .o_halt_exec(halt_x), .o_stop_exec(stop_x),
		.o_irq_req(irq), .o_flags(fq), .o_nmi_req(nmi), .o_test_in(tin),
		.o_test_mask(tmask));

	// Free-running system clock, 4 ns period
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// Count one-cycle pulses so a scenario can tell whether one occurred
	always @(posedge sys_clk) begin
		if (ldv === 1'b1) n_load <= n_load + 1;
		if (unl === 1'b1) n_unl <= n_unl + 1;
	end

	task automatic conclude();
		$display("counts: comparisons=%0d num_errors=%0d", comparisons,
			num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// One APB transfer; holds the request until pready is sampled high
	task automatic apb(input logic wr, input logic [31:0] a,
		input logic [31:0] d);
		int k;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) begin
			num_errors++;
			conclude();
		end
	endtask

	task automatic go(input logic [2:0] c, input logic [3:0] fl);
		@(posedge sys_clk);
		cmd <= c;
		flags <= fl;
		@(posedge sys_clk);
		cmd <= 3'h0;
	endtask

	// Edges until the restart pulse; a long wait ends the run
	task automatic wait_res();
		n = 0;
		do begin
			@(posedge sys_clk);
			#1;
			n++;
		end while (res !== 1'b1 && n < 3000);
		if (n >= 3000) begin
			num_errors++;
			conclude();
		end
	endtask

	// Pin low for ten microseconds, 2500 cycles at 4 ns per cycle
	task automatic hold_pin();
		@(posedge sys_clk);
		pin_n <= 1'b0;
		repeat (2500) @(posedge sys_clk);
		#1;
	endtask

	function automatic logic exp_srv(input logic [3:0] fl);
		if (fl[2] == 1'b0) return fl[1];
		return fl[1] & fl[0];
	endfunction

	initial begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		pin_n = 1'b1;
		wdt = 1'b0;
		mon = 1'b0;
		cpu_full = 1'b0;
		cmd = 3'h0;
		flags = 4'h0;
		void'($urandom(32'h81c3));
		repeat (12) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge sys_clk);
		#1;
		`CHK(hiz & dlow, 1'b1)
		`CHK(thr, `THR_3V5)
		wait_res();
		`CHK(n + 4 >= rw + 1 && n + 4 <= rw + 4, 1'b1)
		`CHK(rvec, 1'b1)
		apb(1'b0, a_ows, 32'h0);
		`CHK(rd[2:0], `OWS_RESET)
		apb(1'b0, a_pfs, 32'h0);
		`CHK(rd, 32'h0)
		apb(1'b0, 32'h10, 32'h0);
		`CHK(er, 1'b1)
		$display("test power_up done");
		for (int i = 0; i < 16; i++) begin
			f = 4'(i);
			go(3'h1, 4'h0);
			go(3'h3, f);
			if (f[3]) begin
				go(3'h5, 4'h8);
				repeat (20) @(posedge sys_clk);
				#1;
				`CHK(cstop, 1'b1)
				go(3'h4, 4'h0);
				wait_res();
				`CHK(rsv, 1'b1)
			end else begin
				wait_res();
				`CHK(rsv, exp_srv(f))
				`CHK(n >= (rsv ? 9 : 3) && n <= (rsv ? 13 : 7), 1'b1)
			end
		end
		// Unmasked test input leaves HALT for the next instruction
		go(3'h1, 4'h0);
		go(3'h5, 4'h0);
		wait_res();
		`CHK(rsv, 1'b0)
		`CHK(n >= 3 && n <= 7, 1'b1)
		$display("test halt_release done");
		for (int i = 0; i < 6; i++) begin
			sel = $urandom % 2;
			apb(1'b1, a_ows, 32'(sel));
			cpu_full <= 1'($urandom);
			f = 4'($urandom) & 4'h7;
			go(3'h2, 4'h0);
			repeat (3) @(posedge sys_clk);
			#1;
			`CHK(ostop & cstop, 1'b1)
			`CHK(pstop, 1'b1)
			`CHK(evo, 1'b1)
			`CHK(thr, `THR_2V5)
			if (i % 2 == 1) go(3'h5, 4'h0);
			else go(3'h3, f);
			wait_res();
			`CHK(rsv, (i % 2 == 1) ? 1'b0 : exp_srv(f))
			`CHK(n >= 2 ** (ob + sel) && n <= 2 ** (ob + sel) + 5, 1'b1)
			repeat (2) @(posedge sys_clk);
			#1;
			`CHK(thr, cpu_full ? `THR_4V5 : `THR_3V5)
		end
		go(3'h3, 4'h2);
		go(3'h2, 4'h0);
		// The stop pulse reaches the block one edge after the command
		@(posedge sys_clk);
		#1;
		`CHK(ostop, 1'b0)
		`CHK(cstop, 1'b1)
		wait_res();
		`CHK(rsv, 1'b1)
		$display("test stop_release done");
		sel = n_load;
		go(3'h1, 4'h0);
		hold_pin();
		`CHK(irst & ostop, 1'b1)
		`CHK(src, `SRC_PIN)
		`CHK(pcu, 1'b1)
		`CHK(n_load - sel, 1)
		@(posedge sys_clk);
		pin_n <= 1'b1;
		wait_res();
		`CHK(rvec, 1'b1)
		apb(1'b1, a_ows, 32'h1);
		sel = n_load;
		go(3'h2, 4'h0);
		hold_pin();
		`CHK(hold & hiz & dlow, 1'b1)
		`CHK(n_load - sel, 0)
		@(posedge sys_clk);
		pin_n <= 1'b1;
		wait_res();
		`CHK(rvec, 1'b1)
		apb(1'b0, a_ows, 32'h0);
		`CHK(rd[2:0], 3'h1)
		$display("test pin_reset done");
		@(posedge sys_clk);
		wdt <= 1'b1;
		@(posedge sys_clk);
		wdt <= 1'b0;
		repeat (4) @(posedge sys_clk);
		#1;
		`CHK(irst, 1'b0)
		`CHK(hiz, 1'b1)
		`CHK(src, `SRC_WDT)
		wait_res();
		`CHK(rvec, 1'b1)
		apb(1'b0, a_pfs, 32'h0);
		`CHK(rd, 32'h0)
		sel = n_unl;
		@(posedge sys_clk);
		mon <= 1'b1;
		repeat (10) @(posedge sys_clk);
		#1;
		`CHK(irst, 1'b1)
		`CHK(src, `SRC_MON)
		`CHK(n_unl - sel, 1)
		@(posedge sys_clk);
		mon <= 1'b0;
		wait_res();
		hold_pin();
		@(posedge sys_clk);
		pin_n <= 1'b1;
		wait_res();
		`CHK(src, `SRC_PIN)
		apb(1'b0, a_pfs, 32'h0);
		`CHK(rd, 32'h1)
		apb(1'b0, a_pfs, 32'h0);
		`CHK(rd, 32'h0)
		$display("test reset_sources done");
		conclude();
	end
endmodule
